// >>> design/pll_cfg_top.sv
// PLL clock conditioning configuration image, shadow and active copies.
// Assumes a single AHB-Lite master and one clock domain.
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pll_cfg_defs.svh"
module pll_cfg_top
   import pll_cfg_pkg::*;
#(
   parameter bit MIXED_SIGNAL = 1'b1,
   parameter bit RESYNC_EN = 1'b1
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Oscillator source and routing
   output logic input_c_osc_source_sel,
   output logic input_b_osc_source_sel,
   output logic input_a_osc_source_sel,
   output logic divider_resync_flag,
   output logic input_c_dynamic_route,
   output logic input_b_dynamic_route,
   output logic input_a_dynamic_route,
   output logic input_c_static_mux_sel,
   output logic input_b_static_mux_sel,
   output logic input_a_static_mux_sel,
   // VCO and phase selection
   output logic [2:0] vco_gear_range,
   output logic [2:0] out3_phase_sel,
   output logic [2:0] out2_phase_sel,
   // Output delays
   output logic [4:0] core_out3_delay,
   output logic [4:0] core_out2_delay,
   output logic [4:0] global_out3_delay,
   output logic [4:0] global_out2_delay,
   output logic [4:0] primary_global_delay,
   // Feedback path
   output logic system_delay_insert,
   output logic [4:0] feedback_delay_value,
   output logic [1:0] feedback_mux_sel,
   output logic ext_feedback_active,
   output logic [4:0] fb_delay_applied,
   // Update events
   output logic config_update_strobe,
   output logic divider_resync_pulse
);
   // ------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------
   localparam logic [`IMG_W-1:0] WMASK =
      MIXED_SIGNAL ? (`WMASK_BASE | `WMASK_OSC) : `WMASK_BASE;
   localparam int RB = `RESYNC_BIT - `IMG_BASE;

   // ------------------------------------------------------------
   // Bus front end
   // ------------------------------------------------------------
   cfg_bus_if acc ();
   cfg_state_t r;
   cfg_state_t n;
   logic [`IMG_W-1:0] wr_img;
   logic ctrl_hit;

   ahb_front u_front (
      .clk(clk),
      .arst_n(arst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata),
      .acc(acc)
   );

   // Update request arriving from a control write
   assign ctrl_hit = acc.wr_en && (acc.wr_addr == `REG_CTRL) &&
      acc.wr_data[`CTRL_UPDATE_BIT];

   // Image word written this cycle, placed at its image position
   always_comb begin
      wr_img = r.shadow;
      if (acc.wr_en && acc.wr_addr == `REG_CFG_LO) begin
         wr_img[31:0] = acc.wr_data;
      end
      if (acc.wr_en && acc.wr_addr == `REG_CFG_HI) begin
         wr_img[`IMG_W-1:32] = acc.wr_data[`HI_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Next state: shadow load, update sequence, read data
   // ------------------------------------------------------------
   always_comb begin
      n = r;
      n.upd_pulse = 1'b0;
      n.resync_pulse = 1'b0;
      // Only writable bits take the new value; 83..81 need the variant
      n.shadow = (wr_img & WMASK) | (r.shadow & ~WMASK);
      // A strobe only marks the request; fields wait for the sequencer
      if (ctrl_hit) begin
         n.upd_pend = 1'b1;
      end
      unique case (r.st)
         UPD_IDLE: begin
            if (r.upd_pend) begin
               n.st = UPD_APPLY;
               n.upd_pend = ctrl_hit;
            end
         end
         UPD_APPLY: begin
            // Whole image moves to the active copy at once
            n.active = r.shadow;
            n.ext_fb = r.shadow[`FBSEL_MSB-`IMG_BASE -: `FBSEL_W] ==
               `FB_EXTERNAL;
            if (r.shadow[`FBSEL_MSB-`IMG_BASE -: `FBSEL_W] ==
                  `FB_PROGDLY) begin
               n.fb_eff = r.shadow[`FBDLY_MSB-`IMG_BASE -: `DLY_W];
            end else begin
               n.fb_eff = '0;
            end
            n.upd_pulse = 1'b1;
            n.st = UPD_RESYNC;
         end
         UPD_RESYNC: begin
            // Dividers resynchronise only when the flag is set
            n.resync_pulse = r.active[RB];
            n.st = UPD_IDLE;
         end
         default: begin
            n.st = UPD_IDLE;
         end
      endcase
      // Read data is taken from the post-write view
      n.rdata = '0;
      if (acc.rd_en) begin
         unique case (acc.rd_addr)
            `REG_CFG_LO: n.rdata = n.shadow[31:0];
            `REG_CFG_HI: n.rdata = {7'h00, n.shadow[`IMG_W-1:32]};
            `REG_ACT_LO: n.rdata = n.active[31:0];
            `REG_ACT_HI: n.rdata = {7'h00, n.active[`IMG_W-1:32]};
            `REG_STATUS: n.rdata = {29'h0000_0000, n.ext_fb,
               (n.st != UPD_IDLE), n.upd_pend};
            default: n.rdata = '0;
         endcase
      end
   end

   // State register; the resync flag resets to its fixed value
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.shadow[RB] <= RESYNC_EN;
         r.active[RB] <= RESYNC_EN;
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // Outputs, slices of the state register except the constant hreadyout and hresp
   // ------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = r.rdata;
   // Oscillator sources and routing
   assign input_c_osc_source_sel = r.active[`OSC_C_BIT-`IMG_BASE];
   assign input_b_osc_source_sel = r.active[`OSC_B_BIT-`IMG_BASE];
   assign input_a_osc_source_sel = r.active[`OSC_A_BIT-`IMG_BASE];
   assign divider_resync_flag = r.active[RB];
   assign input_c_dynamic_route = r.active[`DYN_C_BIT-`IMG_BASE];
   assign input_b_dynamic_route = r.active[`DYN_B_BIT-`IMG_BASE];
   assign input_a_dynamic_route = r.active[`DYN_A_BIT-`IMG_BASE];
   assign input_c_static_mux_sel = r.active[`STAT_C_BIT-`IMG_BASE];
   assign input_b_static_mux_sel = r.active[`STAT_B_BIT-`IMG_BASE];
   assign input_a_static_mux_sel = r.active[`STAT_A_BIT-`IMG_BASE];
   // VCO gear and phase selection
   assign vco_gear_range = r.active[`VCO_MSB-`IMG_BASE -: `SEL3_W];
   assign out3_phase_sel = r.active[`OUT3_PH_MSB-`IMG_BASE -: `SEL3_W];
   assign out2_phase_sel = r.active[`OUT2_PH_MSB-`IMG_BASE -: `SEL3_W];
   // Output delays
   assign core_out3_delay = r.active[`DLY_CORE3_MSB-`IMG_BASE -: `DLY_W];
   assign core_out2_delay = r.active[`DLY_CORE2_MSB-`IMG_BASE -: `DLY_W];
   assign global_out3_delay = r.active[`DLY_GLB3_MSB-`IMG_BASE -: `DLY_W];
   assign global_out2_delay = r.active[`DLY_GLB2_MSB-`IMG_BASE -: `DLY_W];
   assign primary_global_delay =
      r.active[`DLY_PRIM_MSB-`IMG_BASE -: `DLY_W];
   // Feedback path
   assign system_delay_insert = r.active[`SYSDLY_BIT-`IMG_BASE];
   assign feedback_delay_value =
      r.active[`FBDLY_MSB-`IMG_BASE -: `DLY_W];
   assign feedback_mux_sel = r.active[`FBSEL_MSB-`IMG_BASE -: `FBSEL_W];
   assign ext_feedback_active = r.ext_fb;
   assign fb_delay_applied = r.fb_eff;
   // Update events
   assign config_update_strobe = r.upd_pulse;
   assign divider_resync_pulse = r.resync_pulse;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence seq_upd_start;
      r.st == UPD_IDLE && r.upd_pend;
   endsequence

   sequence seq_upd_body;
      r.st == UPD_APPLY ##1 r.st == UPD_RESYNC && config_update_strobe
         ##1 r.st == UPD_IDLE;
   endsequence

   a_update_seq: assert property (seq_upd_start |=> seq_upd_body)
      else $error("update sequence broke order");

   a_strobe_reach: assert property (
      ctrl_hit |-> ##[2:6] config_update_strobe)
      else $error("update strobe never applied");

   a_active_hold: assert property (
      r.st != UPD_APPLY |=> $stable(r.active))
      else $error("active image changed outside update");

   a_active_copy: assert property (
      config_update_strobe |-> r.active == $past(r.shadow))
      else $error("active image differs from loaded image");

   a_resync_pulse: assert property (
      config_update_strobe |=>
      divider_resync_pulse == divider_resync_flag ##1 !divider_resync_pulse)
      else $error("divider resync pulse wrong");

   a_resync_ro: assert property (
      divider_resync_flag == RESYNC_EN && r.shadow[RB] == RESYNC_EN)
      else $error("read-only resync flag altered");

   a_osc_variant: assert property (
      !MIXED_SIGNAL |-> !input_a_osc_source_sel &&
      !input_b_osc_source_sel && !input_c_osc_source_sel)
      else $error("oscillator select set without variant");

   a_fb_external: assert property (
      ext_feedback_active == (feedback_mux_sel == `FB_EXTERNAL))
      else $error("external feedback flag mismatch");

   a_fb_delay: assert property (
      fb_delay_applied == ((feedback_mux_sel == `FB_PROGDLY) ?
      feedback_delay_value : 5'h00))
      else $error("applied feedback delay wrong");

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");

   // Read data stands only in the data phase after a read
   a_rdata_idle: assert property (!acc.rd_en |=> hrdata == 32'h0000_0000)
      else $error("read data left standing");

   // A control write with the update bit set always leaves a pending request behind
   a_pend_set: assert property (ctrl_hit |=> r.upd_pend)
      else $error("update request lost");

   // The applied pulse lasts one cycle and only in the resync step
   a_strobe_once: assert property (
      config_update_strobe |-> r.st == UPD_RESYNC ##1 !config_update_strobe)
      else $error("update strobe malformed");

   // Resync pulse only ever follows an applied update
   a_resync_cause: assert property (
      divider_resync_pulse |-> $past(config_update_strobe))
      else $error("resync pulse without update");

   // Bits above the oscillator selects hold no field and stay clear
   a_hi_reserved: assert property (
      r.shadow[`IMG_W-1 -: 5] == 5'h00 && r.active[`IMG_W-1 -: 5] == 5'h00)
      else $error("reserved image bits set");
endmodule
`default_nettype wire

// >>> design/pll_cfg_defs.svh
// Offsets, field positions, feedback codes and write masks of the PLL configuration block.
// Assumes inclusion by the package and the design files by bare name.
`ifndef PLL_CFG_DEFS_SVH
`define PLL_CFG_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ADDR_W 8
`define REG_CFG_LO 8'h00
`define REG_CFG_HI 8'h04
`define REG_CTRL 8'h08
`define REG_ACT_LO 8'h0c
`define REG_ACT_HI 8'h10
`define REG_STATUS 8'h14
`define CTRL_UPDATE_BIT 0
`define HSIZE_WORD 3'h2

// ---------------------------------------------------------------
// Image span and field positions (absolute bit numbers)
// ---------------------------------------------------------------
`define IMG_BASE 32
`define IMG_W 57
`define HI_W 25
`define OSC_C_BIT 83
`define OSC_B_BIT 82
`define OSC_A_BIT 81
`define RESYNC_BIT 80
`define DYN_C_BIT 79
`define DYN_B_BIT 78
`define DYN_A_BIT 77
`define VCO_MSB 76
`define STAT_C_BIT 73
`define STAT_B_BIT 72
`define STAT_A_BIT 71
`define DLY_CORE3_MSB 70
`define DLY_CORE2_MSB 65
`define DLY_GLB3_MSB 60
`define DLY_GLB2_MSB 55
`define DLY_PRIM_MSB 50
`define SYSDLY_BIT 45
`define FBDLY_MSB 44
`define FBSEL_MSB 39
`define OUT3_PH_MSB 37
`define OUT2_PH_MSB 34
`define DLY_W 5
`define SEL3_W 3
`define FBSEL_W 2

// Feedback mux codes
`define FB_NODELAY 2'h0
`define FB_PROGDLY 2'h1
`define FB_EXTERNAL 2'h2

// Writable image bits when the mixed-signal variant is absent (32..79),
// and the extra oscillator source bits present only in that variant
`define WMASK_BASE 57'h000_ffff_ffff_ffff
`define WMASK_OSC 57'h00e_0000_0000_0000

`endif

// >>> design/pll_cfg_pkg.sv
// Types shared by the PLL configuration block.
// Assumes the defs header is on the include path.
package pll_cfg_pkg;
`include "pll_cfg_defs.svh"

   // Update sequencer, Gray coded along IDLE, APPLY, RESYNC
   typedef enum logic [1:0] {
      UPD_IDLE = 2'h0,
      UPD_APPLY = 2'h1,
      UPD_RESYNC = 2'h3
   } upd_state_t;

   // Whole state of the register file and sequencer
   typedef struct packed {
      logic [`IMG_W-1:0] shadow;
      logic [`IMG_W-1:0] active;
      upd_state_t st;
      logic upd_pend;
      logic upd_pulse;
      logic resync_pulse;
      logic ext_fb;
      logic [`DLY_W-1:0] fb_eff;
      logic [31:0] rdata;
   } cfg_state_t;

   // State of the bus front end
   typedef struct packed {
      logic wr_pend;
      logic [`ADDR_W-1:0] wr_addr;
   } front_state_t;
endpackage

// >>> design/cfg_bus_if.sv
// Internal access port between the bus front end and the register file.
// Assumes a single clock; front end drives, register file consumes.
`timescale 1ns/1ns
`default_nettype none
interface cfg_bus_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic rd_en;
   logic [7:0] rd_addr;
   modport front (output wr_en, wr_addr, wr_data, rd_en, rd_addr);
   modport regs (input wr_en, wr_addr, wr_data, rd_en, rd_addr);
endinterface
`default_nettype wire

// >>> design/ahb_front.sv
// AHB-Lite address/data phase tracker for the configuration registers.
// Assumes one slave with zero wait states and word-only writes.
`timescale 1ns/1ns
`default_nettype none
`include "pll_cfg_defs.svh"
module ahb_front
   import pll_cfg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // AHB-Lite address and data
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   // Access port to the register file
   cfg_bus_if.front acc
);
   front_state_t r;
   front_state_t n;
   logic valid_ap;

   // Address phase accepted when selected, active and the bus is ready
   assign valid_ap = hsel && htrans[1] && hready;

   // Capture a write address phase for use in the following data phase
   always_comb begin
      n = r;
      n.wr_pend = valid_ap && hwrite && (hsize == `HSIZE_WORD);
      if (valid_ap) begin
         n.wr_addr = haddr[`ADDR_W-1:0];
      end
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Write commits in the data phase, read decodes in the address phase
   assign acc.wr_en = r.wr_pend;
   assign acc.wr_addr = r.wr_addr;
   assign acc.wr_data = hwdata;
   assign acc.rd_en = valid_ap && !hwrite;
   assign acc.rd_addr = haddr[`ADDR_W-1:0];
endmodule
`default_nettype wire

// >>> tb/pll_cfg_top_tb.sv
// Self-checking bench for the PLL configuration register block.
// Assumes the package, defs header and access interface compile first.
`timescale 1ns/1ns
`default_nettype none
`include "pll_cfg_defs.svh"
module pll_cfg_top_tb;
   import pll_cfg_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instance
   // ---------------------------------------------------------------
   localparam int B = `IMG_BASE;
   localparam logic [56:0] RST_IMG = 57'h001_0000_0000_0000;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, feedback_mux_sel;
   logic [2:0] hsize, vco_gear_range, out3_phase_sel, out2_phase_sel;
   logic osc_c, osc_b, osc_a, resync_flag, dyn_c, dyn_b, dyn_a;
   logic stat_c, stat_b, stat_a, sys_dly, ext_fb, strobe, resync_pulse;
   logic [4:0] dly_c3, dly_c2, dly_g3, dly_g2, dly_p, fb_dly, fb_app;
   int error_cnt, n_compared, strobe_cnt, i;
   logic [31:0] seed, lo, hi, exp_hi, d;
   logic [56:0] act;

   pll_cfg_top u_pll_cfg_top (.clk(clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .input_c_osc_source_sel(osc_c),
      .input_b_osc_source_sel(osc_b), .input_a_osc_source_sel(osc_a),
      .divider_resync_flag(resync_flag), .input_c_dynamic_route(dyn_c),
      .input_b_dynamic_route(dyn_b), .input_a_dynamic_route(dyn_a),
      .input_c_static_mux_sel(stat_c), .input_b_static_mux_sel(stat_b),
      .input_a_static_mux_sel(stat_a), .vco_gear_range(vco_gear_range),
      .out3_phase_sel(out3_phase_sel), .out2_phase_sel(out2_phase_sel),
      .core_out3_delay(dly_c3), .core_out2_delay(dly_c2),
      .global_out3_delay(dly_g3), .global_out2_delay(dly_g2),
      .primary_global_delay(dly_p), .system_delay_insert(sys_dly),
      .feedback_delay_value(fb_dly), .feedback_mux_sel(feedback_mux_sel),
      .ext_feedback_active(ext_fb), .fb_delay_applied(fb_app),
      .config_update_strobe(strobe), .divider_resync_pulse(resync_pulse));

   // ---------------------------------------------------------------
   // Clock, strobe counter and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Counts update pulses for the back-to-back strobe check
   always @(posedge clk) begin
      if (strobe === 1'b1) strobe_cnt++;
   end
   // Cuts a hang short well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      test_done();
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
   endfunction

   task automatic cmp(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One AHB-Lite single transfer; read data taken at the data edge
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [2:0] sz, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= sz;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      d = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      bus(a, 1'b1, `HSIZE_WORD, wd);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(a, 1'b0, `HSIZE_WORD, 32'h0);
   endtask

   // Compares every applied field against an expected image
   task automatic check_out(input logic [56:0] m);
      logic [1:0] fb;
      fb = m[`FBSEL_MSB-B -: 2];
      cmp("osc_c", m[`OSC_C_BIT-B], osc_c);
      cmp("osc_b", m[`OSC_B_BIT-B], osc_b);
      cmp("osc_a", m[`OSC_A_BIT-B], osc_a);
      cmp("resync_flag", m[`RESYNC_BIT-B], resync_flag);
      cmp("dyn_c", m[`DYN_C_BIT-B], dyn_c);
      cmp("dyn_b", m[`DYN_B_BIT-B], dyn_b);
      cmp("dyn_a", m[`DYN_A_BIT-B], dyn_a);
      cmp("vco", m[`VCO_MSB-B -: 3], vco_gear_range);
      cmp("stat", m[`STAT_C_BIT-B -: 3], {stat_c, stat_b, stat_a});
      cmp("dly_c3", m[`DLY_CORE3_MSB-B -: 5], dly_c3);
      cmp("dly_c2", m[`DLY_CORE2_MSB-B -: 5], dly_c2);
      cmp("dly_g3", m[`DLY_GLB3_MSB-B -: 5], dly_g3);
      cmp("dly_g2", m[`DLY_GLB2_MSB-B -: 5], dly_g2);
      cmp("dly_p", m[`DLY_PRIM_MSB-B -: 5], dly_p);
      cmp("sys_dly", m[`SYSDLY_BIT-B], sys_dly);
      cmp("fb_dly", m[`FBDLY_MSB-B -: 5], fb_dly);
      cmp("fb_sel", fb, feedback_mux_sel);
      cmp("fb_app", fb == 2'h1 ? m[`FBDLY_MSB-B -: 5] : 5'h0, fb_app);
      cmp("ext_fb", fb == `FB_EXTERNAL, ext_fb);
      cmp("ph3", m[`OUT3_PH_MSB-B -: 3], out3_phase_sel);
      cmp("ph2", m[`OUT2_PH_MSB-B -: 3], out2_phase_sel);
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      error_cnt = 0;
      n_compared = 0;
      strobe_cnt = 0;
      seed = 32'h0000_002b;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      #1;
      check_out(RST_IMG);
      cmp("hresp", 32'h0, hresp);
      act = RST_IMG;
      // Random images with corners; feedback codes 0..3 first
      for (i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         lo = seed;
         seed = lfsr(seed);
         hi = seed;
         if (i < 4) lo[7:6] = i[1:0];
         if (i == 4) {hi, lo} = {32'hffff_ffff, 32'hffff_ffff};
         if (i == 5) {hi, lo} = 64'h0;
         exp_hi = (hi & 32'h000e_ffff) | 32'h0001_0000;
         wr(`REG_CFG_LO, lo);
         wr(`REG_CFG_HI, hi);
         rd(`REG_CFG_LO);
         cmp("cfg_lo", lo, d);
         rd(`REG_CFG_HI);
         cmp("cfg_hi", exp_hi, d);
         check_out(act);
         wr(`REG_CTRL, 32'h1);
         @(posedge clk);
         #1;
         cmp("strobe_early", 32'h0, strobe);
         @(posedge clk);
         #1;
         act = {exp_hi[24:0], lo};
         cmp("strobe", 32'h1, strobe);
         check_out(act);
         @(posedge clk);
         #1;
         cmp("resync_pulse", 32'h1, resync_pulse);
         rd(`REG_ACT_HI);
         cmp("act_hi", exp_hi, d);
         rd(`REG_ACT_LO);
         cmp("act_lo", lo, d);
         rd(`REG_STATUS);
         cmp("status", {29'h0, act[7:6] == `FB_EXTERNAL, 2'h0}, d);
      end
      // Refused accesses: byte write, unmapped place, write-only control
      bus(`REG_CFG_LO, 1'b1, 3'h0, ~lo);
      rd(`REG_CFG_LO);
      cmp("byte_write", lo, d);
      wr(8'h18, seed);
      rd(8'h18);
      cmp("unmapped", 32'h0, d);
      rd(`REG_CTRL);
      cmp("ctrl_read", 32'h0, d);
      // A second strobe, written during the running update, queues one more
      strobe_cnt = 0;
      wr(`REG_CTRL, 32'h1);
      wr(`REG_CTRL, 32'h1);
      repeat (10) @(posedge clk);
      cmp("strobe_cnt", 32'd2, strobe_cnt);
      check_out(act);
      // Reset in mid-run restores the cleared image
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check_out(RST_IMG);
      // Second release: the loaded image must come back cleared
      arst_n <= 1'b1;
      rd(`REG_CFG_HI);
      cmp("rst_hi", 32'h0001_0000, d);
      test_done();
   end
endmodule
`default_nettype wire
